// >>> common/usart_special_pkg.sv
// constants shared by the serial-port special-mode logic
package usart_special_pkg;

  // ************************************************************
  // operating-mode field encodings
  // ************************************************************
  localparam logic [3:0] MODE_NORMAL    = 4'h0;
  localparam logic [3:0] MODE_HANDSHAKE = 4'h2;
  localparam logic [3:0] MODE_SC_CHAR   = 4'h4;
  localparam logic [3:0] MODE_SC_BLOCK  = 4'h5;

  // ************************************************************
  // field layouts and reset values
  // ************************************************************
  localparam int         MODE_W        = 4;
  localparam int         DIV_W         = 16;
  localparam int         DATA_W        = 8;
  localparam int         CHAR_BITS     = 8;
  localparam logic [7:0] BREAK_DATA    = 8'h00;
  localparam logic [15:0] DIV_RESET    = 16'h0004;
  localparam int         FIFO_DEPTH    = 16;

  // ************************************************************
  // timing counts, in samples of the 16x oversampled bit; guard and error-bit lengths in bits
  // ************************************************************
  localparam int         OVERSAMPLE    = 16;
  localparam logic [3:0] SAMPLE_MID    = 4'h7;
  localparam logic [3:0] SAMPLE_LAST   = 4'hF;
  localparam logic [3:0] BRK_END_ASYNC = 4'h2;
  localparam logic [3:0] BRK_END_SYNC  = 4'h1;
  localparam logic [1:0] GUARD_BITS    = 2'h2;
  localparam logic [1:0] NACK_BITS     = 2'h1;

  // ************************************************************
  // bit-level state machines
  // ************************************************************
  typedef enum logic [2:0] {
    TX_IDLE   = 3'b000,
    TX_START  = 3'b001,
    TX_DATA   = 3'b010,
    TX_PARITY = 3'b011,
    TX_STOP   = 3'b100,
    TX_GUARD  = 3'b101
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE   = 3'b000,
    RX_START  = 3'b001,
    RX_DATA   = 3'b010,
    RX_PARITY = 3'b011,
    RX_STOP   = 3'b100,
    RX_NACK   = 3'b101,
    RX_GUARD  = 3'b110,
    RX_BREAK  = 3'b111
  } rx_state_t;

endpackage : usart_special_pkg

// >>> core/sync_fifo.sv
// synchronous valid/ready FIFO for the transmit data path
`timescale 1ns/1ps
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : sync_fifo

// >>> core/usart_special.sv
// serial port: receive break, hardware handshake and smart-card modes
// Summary of operation
// - break is a character whose data, parity and stop bits all read low
// - low stop bit of a break sets the break flag; reset command clears it
// - line high 2/16 bit (async) or one sample (sync) ends break, sets flag
// - handshaking is on when the mode field holds 0x2
// - handshake: request-to-send high while receiver off or DMA buffer full
// - a new DMA buffer clears buffer full, so request-to-send falls
// - clear-to-send high holds off the next character, current one completes
// - smart-card mode: 0x4 character protocol, 0x5 block protocol
// - smart-card bit rate comes from the card clock given on the clock pin
// - smart-card data pin driven only while transmitting or driving the error bit, always received
// - smart-card format fixed: 8 data, even parity; bit order still selectable
// - character protocol: start, 8 data, parity, two-bit guard, line released
// - no parity error: line stays high in guard, next character follows
// - parity error: receiver drives one low bit, then the full guard time
// - parity error in character protocol: no data stored, parity flag set
`timescale 1ns/1ps
module usart_special
  import usart_special_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // configuration
  input  wire logic [MODE_W-1:0] usart_mode,
  input  wire logic              sync_mode,
  input  wire logic              msb_first_select,
  input  wire logic              two_stop_bits,
  input  wire logic [7:0]        parity_type_field,
  input  wire logic [DIV_W-1:0]  clock_divider,
  input  wire logic              rx_enable,
  input  wire logic              tx_enable,
  input  wire logic              reset_status_cmd,
  // dma status
  input  wire logic              rx_buffer_full_status,
  // transmit data stream
  input  wire logic              tx_valid,
  output logic                   tx_ready,
  input  wire logic [DATA_W-1:0] tx_data,
  // receive data
  output logic                   rx_valid,
  output logic [DATA_W-1:0]      rx_holding_reg,
  // status
  output logic                   receive_break_flag,
  output logic                   parity_error_flag,
  output logic                   framing_error_flag,
  output logic                   tx_empty,
  // line pins
  input  wire logic              rxd_in,
  input  wire logic              txd_in,
  output logic                   txd_out,
  output logic                   txd_oe,
  output logic                   rts_out,
  input  wire logic              cts_in,
  output logic                   sck_out
);

  // ************************************************************
  // mode decode
  // ************************************************************
  wire sc_char   = (usart_mode == MODE_SC_CHAR);
  wire sc_mode   = sc_char || (usart_mode == MODE_SC_BLOCK);
  wire handshake = (usart_mode == MODE_HANDSHAKE);
  // fixed format in smart-card mode ignores the parity-type input
  wire par_en    = sc_mode || (parity_type_field != 8'h00);
  wire par_odd   = sc_mode ? 1'b0 : parity_type_field[0];

  // ************************************************************
  // bit-rate generator: 16 samples per bit; card clock toggles on each sample tick
  // ************************************************************
  logic [DIV_W-1:0] div_cnt_reg;
  logic             sck_reg;
  wire              tick = (div_cnt_reg == '0);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      div_cnt_reg <= DIV_RESET;
      sck_reg     <= 1'b0;
    end else if (tick) begin
      div_cnt_reg <= clock_divider;
      sck_reg     <= ~sck_reg;
    end else begin
      div_cnt_reg <= div_cnt_reg - DIV_W'(1);
    end
  end

  // ************************************************************
  // transmit fifo
  // ************************************************************
  logic              fifo_valid;
  logic              fifo_ready;
  logic [DATA_W-1:0] fifo_data;

  sync_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready),
    .out_data  (fifo_data)
  );

  // ************************************************************
  // transmitter
  // ************************************************************
  tx_state_t         tx_state_reg;
  logic [3:0]        tx_smp_reg;
  logic [3:0]        tx_bit_reg;
  logic [DATA_W-1:0] tx_shift_reg;
  logic              tx_par_reg;
  logic              txd_reg;
  logic              txd_oe_reg;

  wire tx_bit_end = tick && (tx_smp_reg == SAMPLE_LAST);
  // clear-to-send only gates the start of a new character
  wire cts_hold   = handshake && cts_in;
  wire tx_go      = (tx_state_reg == TX_IDLE) && tx_enable && fifo_valid && !cts_hold;
  assign fifo_ready = tx_go;
  wire [1:0] stop_len  = two_stop_bits ? 2'h2 : 2'h1;
  wire       tx_out_bit = msb_first_select ? tx_shift_reg[7] : tx_shift_reg[0];
  wire [DATA_W-1:0] tx_shifted = msb_first_select ? {tx_shift_reg[6:0], 1'b0}
                                                  : {1'b0, tx_shift_reg[7:1]};

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_state_reg <= TX_IDLE;
      tx_smp_reg   <= 4'h0;
      tx_bit_reg   <= 4'h0;
      tx_shift_reg <= 8'h00;
      tx_par_reg   <= 1'b0;
    end else begin
      if (tick) begin
        tx_smp_reg <= tx_smp_reg + 4'h1;
      end
      case (tx_state_reg)
        TX_IDLE: begin
          if (tx_go) begin
            tx_shift_reg <= fifo_data;
            tx_par_reg   <= par_odd;
            tx_smp_reg   <= 4'h0;
            tx_state_reg <= TX_START;
          end
        end
        TX_START: begin
          if (tx_bit_end) begin
            tx_bit_reg   <= 4'h0;
            tx_state_reg <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (tx_bit_end) begin
            tx_par_reg   <= tx_par_reg ^ tx_out_bit;
            tx_shift_reg <= tx_shifted;
            tx_bit_reg   <= tx_bit_reg + 4'h1;
            if (tx_bit_reg == 4'(CHAR_BITS - 1)) begin
              tx_state_reg <= par_en ? TX_PARITY : TX_STOP;
              tx_bit_reg   <= 4'h0;
            end
          end
        end
        TX_PARITY: begin
          if (tx_bit_end) begin
            tx_bit_reg   <= 4'h0;
            tx_state_reg <= sc_char ? TX_GUARD : TX_STOP;
          end
        end
        TX_STOP: begin
          if (tx_bit_end) begin
            tx_bit_reg <= tx_bit_reg + 4'h1;
            if (tx_bit_reg[1:0] == stop_len - 2'h1) begin
              tx_state_reg <= TX_IDLE;
            end
          end
        end
        TX_GUARD: begin
          // released line; a card low here is its error bit, which does not lengthen the two-bit guard
          if (tx_bit_end) begin
            tx_bit_reg <= tx_bit_reg + 4'h1;
            if (tx_bit_reg[1:0] == GUARD_BITS - 2'h1 + {1'b0, ~txd_in & (tx_bit_reg == 4'h0)}) begin
              tx_state_reg <= TX_IDLE;
            end
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // line driver: released in smart-card mode except while bits are shifted out or the error bit is driven
  wire tx_active = (tx_state_reg == TX_START) || (tx_state_reg == TX_DATA)
                || (tx_state_reg == TX_PARITY);
  logic txd_next;
  always_comb begin
    case (tx_state_reg)
      TX_START:  txd_next = 1'b0;
      TX_DATA:   txd_next = tx_out_bit;
      TX_PARITY: txd_next = tx_par_reg;
      default:   txd_next = 1'b1;
    endcase
  end

  // ************************************************************
  // receiver; in smart-card mode it listens on the data pin
  // ************************************************************
  wire rx_line = sc_mode ? txd_in : rxd_in;

  rx_state_t         rx_state_reg;
  logic [3:0]        rx_smp_reg;
  logic [3:0]        rx_bit_reg;
  logic [DATA_W-1:0] rx_shift_reg;
  logic              rx_par_reg;
  logic              rx_all_low_reg;
  logic              rx_nack_drive_reg;
  logic [3:0]        brk_high_reg;

  wire rx_mid     = tick && (rx_smp_reg == SAMPLE_MID);
  wire rx_bit_end = tick && (rx_smp_reg == SAMPLE_LAST);
  wire [DATA_W-1:0] rx_shifted = msb_first_select ? {rx_shift_reg[6:0], rx_line}
                                                  : {rx_line, rx_shift_reg[7:1]};
  // in smart-card mode parity covers eight data bits plus the parity bit
  wire par_bad      = par_en && (rx_par_reg ^ rx_line ^ par_odd);
  wire brk_detect   = rx_mid && (rx_state_reg == RX_STOP) && rx_all_low_reg && !rx_line;
  wire [3:0] brk_end_len = sync_mode ? BRK_END_SYNC : BRK_END_ASYNC;
  wire brk_end      = (rx_state_reg == RX_BREAK) && tick && rx_line
                   && (brk_high_reg + 4'h1 >= brk_end_len);
  wire frame_set    = rx_mid && (rx_state_reg == RX_STOP) && !rx_line
                   && !rx_all_low_reg;
  wire par_set      = rx_mid && (rx_state_reg == RX_PARITY) && par_bad;
  wire store_ok     = rx_mid && (rx_state_reg == RX_STOP) && rx_line
                   && !(sc_char && rx_par_reg);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_state_reg      <= RX_IDLE;
      rx_smp_reg        <= 4'h0;
      rx_bit_reg        <= 4'h0;
      rx_shift_reg      <= 8'h00;
      rx_par_reg        <= 1'b0;
      rx_all_low_reg    <= 1'b0;
      rx_nack_drive_reg <= 1'b0;
      brk_high_reg      <= 4'h0;
    end else if (!rx_enable) begin
      rx_state_reg      <= RX_IDLE;
      rx_nack_drive_reg <= 1'b0;
    end else begin
      if (tick) begin
        rx_smp_reg <= rx_smp_reg + 4'h1;
      end
      case (rx_state_reg)
        RX_IDLE: begin
          if (tick && !rx_line) begin
            rx_smp_reg     <= 4'h1;
            rx_par_reg     <= 1'b0;
            rx_all_low_reg <= 1'b1;
            rx_state_reg   <= RX_START;
          end
        end
        RX_START: begin
          if (rx_mid && rx_line) begin
            rx_state_reg <= RX_IDLE;
          end else if (rx_bit_end) begin
            rx_bit_reg   <= 4'h0;
            rx_state_reg <= RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_mid) begin
            rx_shift_reg   <= rx_shifted;
            rx_par_reg     <= rx_par_reg ^ rx_line;
            rx_all_low_reg <= rx_all_low_reg & ~rx_line;
          end
          if (rx_bit_end) begin
            rx_bit_reg <= rx_bit_reg + 4'h1;
            if (rx_bit_reg == 4'(CHAR_BITS - 1)) begin
              rx_state_reg <= par_en ? RX_PARITY : RX_STOP;
            end
          end
        end
        RX_PARITY: begin
          if (rx_mid) begin
            rx_all_low_reg <= rx_all_low_reg & ~rx_line;
            rx_par_reg     <= par_bad;                              // now the error mark
          end
          if (rx_bit_end) begin
            rx_bit_reg <= 4'h0;
            if (sc_char) begin
              rx_nack_drive_reg <= rx_par_reg;
              rx_state_reg      <= rx_par_reg ? RX_NACK : RX_GUARD;
            end else begin
              rx_state_reg <= RX_STOP;
            end
          end
        end
        RX_NACK: begin
          if (rx_bit_end) begin
            rx_nack_drive_reg <= 1'b0;
            rx_state_reg      <= RX_GUARD;
          end
        end
        RX_GUARD: begin
          // two guard bits follow the error bit, or the parity bit directly
          if (rx_bit_end) begin
            rx_bit_reg <= rx_bit_reg + 4'h1;
            if (rx_bit_reg[1:0] == GUARD_BITS - 2'h1) begin
              rx_state_reg <= RX_IDLE;
            end
          end
        end
        RX_STOP: begin
          if (rx_mid) begin
            brk_high_reg <= 4'h0;
            rx_state_reg <= (rx_all_low_reg && !rx_line) ? RX_BREAK : RX_IDLE;
          end
        end
        RX_BREAK: begin
          if (tick) begin
            brk_high_reg <= rx_line ? brk_high_reg + 4'h1 : 4'h0;
          end
          if (brk_end) begin
            rx_state_reg <= RX_IDLE;
          end
        end
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  // smart-card character-protocol stores happen at the end of the guard time
  wire sc_store = sc_char && (rx_state_reg == RX_GUARD) && rx_bit_end && !rx_par_reg
               && (rx_bit_reg[1:0] == GUARD_BITS - 2'h1);
  wire load_rhr = (!sc_char && store_ok) || sc_store;

  // ************************************************************
  // status flags: a set in the same cycle as the clear wins
  // ************************************************************
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      receive_break_flag <= 1'b0;
      parity_error_flag  <= 1'b0;
      framing_error_flag <= 1'b0;
      rx_valid           <= 1'b0;
      rx_holding_reg     <= 8'h00;
    end else begin
      receive_break_flag <= (brk_detect || brk_end)
                         || (receive_break_flag && !reset_status_cmd);
      parity_error_flag  <= par_set || (parity_error_flag && !reset_status_cmd);
      // break keeps the framing flag clear
      framing_error_flag <= frame_set || (framing_error_flag && !reset_status_cmd);
      rx_valid           <= load_rhr;
      if (load_rhr) begin
        rx_holding_reg <= rx_shift_reg;
      end
    end
  end

  // ************************************************************
  // pins
  // ************************************************************
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      txd_reg    <= 1'b1;
      txd_oe_reg <= 1'b1;
      rts_out    <= 1'b0;
      sck_out    <= 1'b0;
      tx_empty   <= 1'b1;
      txd_out    <= 1'b1;
      txd_oe     <= 1'b1;
    end else begin
      txd_reg    <= rx_nack_drive_reg ? 1'b0 : txd_next;
      txd_oe_reg <= !sc_mode || tx_active || rx_nack_drive_reg;
      txd_out    <= txd_reg;
      txd_oe     <= txd_oe_reg;
      // rts follows receiver enable and dma buffer-full, registered one cycle later
      rts_out    <= handshake && (!rx_enable || rx_buffer_full_status);
      sck_out    <= sc_mode && sck_reg;
      tx_empty   <= (tx_state_reg == TX_IDLE) && !fifo_valid;
    end
  end

endmodule : usart_special

// >>> verification/usart_special_assertions.sv
// assertion checker for the serial-port special-mode logic
`timescale 1ns/1ps
module usart_special_assertions
  import usart_special_pkg::*;
(
  // clock and reset
  input wire logic              core_clk,
  input wire logic              rst_n,
  // inputs of the watched block
  input wire logic [MODE_W-1:0] usart_mode,
  input wire logic [DIV_W-1:0]  clock_divider,
  input wire logic              rx_enable,
  input wire logic              reset_status_cmd,
  input wire logic              rx_buffer_full_status,
  // outputs of the watched block
  input wire logic              rx_valid,
  input wire logic              receive_break_flag,
  input wire logic              parity_error_flag,
  input wire logic              framing_error_flag,
  input wire logic              tx_empty,
  input wire logic              txd_oe,
  input wire logic              rts_out,
  input wire logic              sck_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire logic hs   = usart_mode == MODE_HANDSHAKE;
  wire logic scc  = usart_mode == MODE_SC_CHAR;
  wire logic sc   = scc || usart_mode == MODE_SC_BLOCK;
  wire logic full = rx_buffer_full_status;
  wire logic brk  = receive_break_flag;
  wire logic fast = clock_divider == 16'h0000;
  // idle transmitter with the receiver off must leave the pin released in smart-card mode
  wire logic idle = tx_empty && !rx_enable;

  AST_RTS_HIGH: assert property (hs && (!rx_enable || full) |=> rts_out)
    else $error("rts low while receiver off or buffer full");
  AST_RTS_LOW: assert property (hs && rx_enable && !full |=> !rts_out)
    else $error("rts high with receiver on and buffer free");
  AST_RTS_MODE: assert property (!hs |=> !rts_out)
    else $error("rts high outside handshake mode");
  AST_BRK_NOFRAME: assert property ($rose(brk) |-> !$rose(framing_error_flag))
    else $error("framing flag raised with break");
  AST_BRK_CLEAR: assert property ($fell(brk) |-> $past(reset_status_cmd))
    else $error("break flag cleared without command");
  AST_PAR_NOSTORE: assert property ($rose(parity_error_flag) && scc |-> !rx_valid [*8])
    else $error("byte delivered with parity error");
  AST_OE_NORMAL: assert property (!sc |=> txd_oe)
    else $error("pin released outside smart-card mode");
  AST_OE_RELEASE: assert property (sc && $past(sc, 3) && idle && $past(idle, 3) |-> !txd_oe)
    else $error("pin driven while transmitter idle");
  AST_SCK_OFF: assert property (!sc |=> !sck_out)
    else $error("card clock running outside smart-card mode");
  AST_SCK_RUN: assert property (sc && fast && $stable(usart_mode) |=> $changed(sck_out))
    else $error("card clock not toggling on sample tick");

  cover property ($rose(brk));
  cover property ($rose(parity_error_flag) && scc);
  cover property (rx_valid && sc);
  cover property ($rose(rts_out));
endmodule : usart_special_assertions

bind usart_special usart_special_assertions i_usart_special_assertions (
  .core_clk, .rst_n, .usart_mode, .clock_divider, .rx_enable, .reset_status_cmd,
  .rx_buffer_full_status, .rx_valid, .receive_break_flag, .parity_error_flag,
  .framing_error_flag, .tx_empty, .txd_oe, .rts_out, .sck_out
);

// >>> verification/far_serial.sv
// far-end serial device and smart-card model
`timescale 1ns/1ps
module far_serial (
  // clock
  input  wire logic core_clk,
  // handshake and line sense
  input  wire logic rts_in,
  input  wire logic io_in,
  // line drive, pulled high when released
  output logic      line
);
  localparam int BIT = 16;
  initial line = 1'b1;
  // ************
  // send n bits, first bit first
  // ************
  task automatic send(input logic [11:0] b, input int n);
    int w;
    w = 0;
    while (rts_in && w < 4000) begin
      @(posedge core_clk);
      w++;
    end
    for (int i = 0; i < n; i++) begin
      line <= b[i];
      repeat (BIT) @(posedge core_clk);
    end
    line <= 1'b1;
  endtask : send
  // ************
  // reject the next card-bound character
  // ************
  task automatic nack();
    int w;
    w = 0;
    while (io_in !== 1'b0 && w < 4000) begin
      @(posedge core_clk);
      w++;
    end
    repeat (10 * BIT + 4) @(posedge core_clk);
    line <= 1'b0;
    repeat (BIT) @(posedge core_clk);
    line <= 1'b1;
  endtask : nack
endmodule : far_serial

// >>> verification/usart_special_tb.sv
// self-checking bench for the serial-port special-mode logic
`timescale 1ns/1ps
module usart_special_tb
  import usart_special_pkg::*;
;
  localparam int BIT = 16;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [MODE_W-1:0] usart_mode = MODE_NORMAL;
  logic msb_first_select = 1'b0;
  logic [7:0] parity_type_field = 8'h00;
  logic rx_enable = 1'b0;
  logic tx_enable = 1'b0;
  logic reset_status_cmd = 1'b0;
  logic rx_buffer_full_status = 1'b0;
  logic tx_valid = 1'b0;
  logic cts_in = 1'b0;
  logic [DATA_W-1:0] tx_data = 8'h00;
  logic tx_ready, rx_valid, receive_break_flag, parity_error_flag, framing_error_flag;
  logic tx_empty, txd_out, txd_oe, rts_out, far_line, oe, ok;
  logic [DATA_W-1:0] rx_holding_reg;
  logic [31:0] seed = 32'h302EC1DE;
  logic [7:0] q[$];
  logic [11:0] b;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  // the pin is pulled high; either side may pull it low
  wire logic io = (txd_oe ? txd_out : 1'b1) & far_line;

  always #50 core_clk = ~core_clk;

  usart_special i_usart_special (.core_clk(core_clk), .rst_n(rst_n), .usart_mode(usart_mode),
    .sync_mode(1'b0), .msb_first_select(msb_first_select), .two_stop_bits(1'b0),
    .parity_type_field(parity_type_field), .clock_divider(16'h0000), .rx_enable(rx_enable),
    .tx_enable(tx_enable), .reset_status_cmd(reset_status_cmd),
    .rx_buffer_full_status(rx_buffer_full_status), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .rx_valid(rx_valid), .rx_holding_reg(rx_holding_reg),
    .receive_break_flag(receive_break_flag), .parity_error_flag(parity_error_flag),
    .framing_error_flag(framing_error_flag), .tx_empty(tx_empty), .rxd_in(far_line),
    .txd_in(io), .txd_out(txd_out), .txd_oe(txd_oe), .rts_out(rts_out), .cts_in(cts_in),
    .sck_out());
  far_serial i_far_serial (.core_clk(core_clk), .rts_in(rts_out), .io_in(io), .line(far_line));

  // ************
  // helpers
  // ************
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xs
  function automatic logic [7:0] ord(input logic [7:0] d);
    return msb_first_select ? {<<{d}} : d;
  endfunction : ord
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic final_report();
    if (n_fail == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report
  // ready before the edge decides whether that edge takes the byte
  task automatic push(input logic [7:0] d, output logic taken);
    tx_valid <= 1'b1;
    tx_data <= d;
    @(negedge core_clk);
    taken = tx_ready;
    @(posedge core_clk);
  endtask : push
  task automatic get_tx(input int n, output logic [11:0] bits, output logic oe_g);
    int w;
    w = 0;
    bits = 12'hFFF;
    oe_g = 1'b1;
    while (io !== 1'b0 && w < 4000) begin
      @(posedge core_clk);
      w++;
    end
    repeat (BIT / 2) @(posedge core_clk);
    for (int i = 0; i < n; i++) begin
      bits[i] = io;
      if (i == 10) oe_g = txd_oe;
      if (i < n - 1) repeat (BIT) @(posedge core_clk);
    end
  endtask : get_tx
  task automatic sc_rx(input logic [7:0] d, input logic bad);
    logic got;
    got = 1'b0;
    reset_status_cmd <= 1'b1;
    @(posedge core_clk);
    reset_status_cmd <= 1'b0;
    @(posedge core_clk);
    fork
      i_far_serial.send({2'b11, ^d ^ bad, ord(d), 1'b0}, 12);
      begin
        repeat (9 * BIT) @(posedge core_clk);
        for (int k = 0; k < 160; k++) begin
          @(posedge core_clk);
          if (k == BIT + 10) check({11'h0, io}, {11'h0, !(bad && usart_mode == MODE_SC_CHAR)});
          if (rx_valid === 1'b1) begin
            got = 1'b1;
            check({4'h0, rx_holding_reg}, {4'h0, d});
          end
        end
      end
    join
    check({10'h0, got, parity_error_flag}, {10'h0, !bad, bad});
  endtask : sc_rx

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end

  // ************
  // main sequence
  // ************
  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    rx_enable <= 1'b1;
    @(posedge core_clk);
    fork
      i_far_serial.send(12'h000, 12);
      begin
        repeat (10 * BIT + 8) @(posedge core_clk);
        check({10'h0, receive_break_flag, framing_error_flag}, 12'h2);
        reset_status_cmd <= 1'b1;
        @(posedge core_clk);
        reset_status_cmd <= 1'b0;
        repeat (4) @(posedge core_clk);
        check({11'h0, receive_break_flag}, 12'h0);
      end
    join
    repeat (BIT) @(posedge core_clk);
    check({10'h0, receive_break_flag, framing_error_flag}, 12'h2);
    for (int j = 0; j < 8; j++) begin
      usart_mode <= j[2] ? MODE_HANDSHAKE : MODE_NORMAL;
      rx_enable <= j[0];
      rx_buffer_full_status <= j[1];
      repeat (3) @(posedge core_clk);
      check({11'h0, rts_out}, {11'h0, j[2] & (!j[0] | j[1])});
    end
    rx_buffer_full_status <= 1'b0;
    tx_enable <= 1'b1;
    cts_in <= 1'b1;
    seed = xs(seed);
    msb_first_select <= seed[8];
    @(posedge core_clk);
    do begin
      seed = xs(seed);
      push(seed[7:0], ok);
      if (ok) q.push_back(seed[7:0]);
    end while (ok && q.size() < 20);
    tx_valid <= 1'b0;
    check({9'h0, q.size() >= FIFO_DEPTH, io, tx_empty}, 12'h6);
    cts_in <= 1'b0;
    foreach (q[i]) begin
      fork
        get_tx(i == 0 ? 12 : 10, b, oe);
        if (i == 0) begin
          repeat (3 * BIT) @(posedge core_clk);
          cts_in <= 1'b1;
        end
      join
      check(b, {3'b111, ord(q[i]), 1'b0});
      if (i == 0) begin
        repeat (4 * BIT) @(posedge core_clk);
        check({11'h0, io}, 12'h1);
        cts_in <= 1'b0;
      end
    end
    usart_mode <= MODE_SC_CHAR;
    rx_enable <= 1'b0;
    parity_type_field <= seed[15:8];
    @(posedge core_clk);
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      push(seed[7:0], ok);
      tx_valid <= 1'b0;
      fork
        get_tx(12, b, oe);
        if (i == 1) i_far_serial.nack();
      join
      check(b, {1'b1, i != 1, ^seed[7:0], ord(seed[7:0]), 1'b0});
      check({11'h0, oe}, 12'h0);
    end
    tx_enable <= 1'b0;
    rx_enable <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      usart_mode <= i < 3 ? MODE_SC_CHAR : MODE_SC_BLOCK;
      msb_first_select <= seed[9];
      parity_type_field <= seed[17:10];
      sc_rx(seed[7:0], i == 1);
    end
    final_report();
  end
endmodule : usart_special_tb
